// ### hw/lpsc_pad_ctrl.sv
module lpsc_pad_ctrl #(
  parameter int PADS = lpsc_pkg::LPSC_PADS
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 externalResetInput_n,
  input  wire lpsc_pkg::lpsc_mode_t powerMode,
  input  wire logic                 standbyPinLevel,
  input  wire logic                 mainOscRunning,
  input  wire lpsc_pkg::lpsc_fn_t   padFunc [PADS],
  input  wire logic [PADS-1:0]      periphActive,
  input  wire logic [PADS-1:0]      periphOut,
  input  wire logic [PADS-1:0]      periphOe,
  input  wire logic [PADS-1:0]      portOut,
  input  wire logic [PADS-1:0]      portOe,
  input  wire logic [PADS-1:0]      deepGpioSel,
  input  wire logic [PADS-1:0]      padIn,
  output logic      [PADS-1:0]      padOut,
  output logic      [PADS-1:0]      padOe,
  output logic      [PADS-1:0]      coreIn,
  output logic      [PADS-1:0]      analogEn,
  output logic      [PADS-1:0]      wakeupIn
);

  // Refuse a pad count the logic cannot serve
  if (PADS < 1) begin : gBadPads
    $error("PADS must be at least one");
  end

  // ****************************************
  // Input synchronisation
  // ****************************************
  logic            resetInSync_n;
  logic [PADS-1:0] padInSync;

  lpsc_sync2 #(.W(PADS + 1)) uSync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .asyncIn ({externalResetInput_n, padIn}),
    .syncOut ({resetInSync_n, padInSync})
  );

  // ****************************************
  // Low-power entry capture
  // ****************************************
  logic            lowPwr;
  logic            lowPwrReg;
  logic            lowPwrNext;
  logic [PADS-1:0] holdOutReg;
  logic [PADS-1:0] holdOutNext;
  logic [PADS-1:0] holdOeReg;
  logic [PADS-1:0] holdOeNext;
  logic [PADS-1:0] liveOut;
  logic [PADS-1:0] liveOe;

  assign lowPwr = (powerMode == lpsc_pkg::LPSC_MODE_STOP) || (powerMode == lpsc_pkg::LPSC_MODE_DEEP);

  // Snapshot pads on the entry edge
  always_comb begin
    lowPwrNext  = lowPwr;
    holdOutNext = holdOutReg;
    holdOeNext  = holdOeReg;
    if (lowPwr && !lowPwrReg) begin
      holdOutNext = liveOut;
      holdOeNext  = liveOe;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowPwrReg  <= 1'b0;
      holdOutReg <= '0;
      holdOeReg  <= '0;
    end else begin
      lowPwrReg  <= lowPwrNext;
      holdOutReg <= holdOutNext;
      holdOeReg  <= holdOeNext;
    end
  end

  // ****************************************
  // Per-pad state selection
  // ****************************************
  logic [PADS-1:0] outNext;
  logic [PADS-1:0] oeNext;
  logic [PADS-1:0] ieNext;
  logic [PADS-1:0] aeNext;
  logic [PADS-1:0] wkNext;
  logic [PADS-1:0] outReg;
  logic [PADS-1:0] oeReg;
  logic [PADS-1:0] ieReg;
  logic [PADS-1:0] aeReg;
  logic [PADS-1:0] wkReg;

  for (genvar i = 0; i < PADS; i++) begin : gPad
    // Normal run drive per function
    always_comb begin
      liveOut[i] = portOut[i];
      liveOe[i]  = portOe[i];
      if (padFunc[i] == lpsc_pkg::LPSC_FN_PERIPH || padFunc[i] == lpsc_pkg::LPSC_FN_XTAL_OUT) begin
        liveOut[i] = periphOut[i];
        liveOe[i]  = periphOe[i];
      end else if (padFunc[i] != lpsc_pkg::LPSC_FN_GPIO) begin
        liveOut[i] = 1'b0;
        liveOe[i]  = 1'b0;
      end
    end

    // Pad outcome for current mode
    always_comb begin
      logic hold;
      logic useGpio;
      hold    = 1'b0;
      useGpio = 1'b0;
      outNext[i] = 1'b0;
      oeNext[i]  = 1'b0;
      ieNext[i]  = 1'b0;
      aeNext[i]  = 1'b0;
      wkNext[i]  = 1'b0;
      if (!resetInSync_n || powerMode == lpsc_pkg::LPSC_MODE_POR
          || powerMode == lpsc_pkg::LPSC_MODE_INT_RST) begin
        hold = 1'b0;
      end else begin
        case (powerMode)
          lpsc_pkg::LPSC_MODE_RUN: begin
            outNext[i] = liveOut[i];
            oeNext[i]  = liveOe[i];
            ieNext[i]  = 1'b1;
          end
          lpsc_pkg::LPSC_MODE_STOP: hold = !standbyPinLevel;
          lpsc_pkg::LPSC_MODE_DEEP: begin
            hold    = !standbyPinLevel;
            useGpio = deepGpioSel[i] && !standbyPinLevel;
          end
          lpsc_pkg::LPSC_MODE_DEEP_RET: useGpio = deepGpioSel[i];
          default: hold = 1'b0;
        endcase
        if (hold) begin
          if (padFunc[i] == lpsc_pkg::LPSC_FN_PERIPH && periphActive[i]) begin
            outNext[i] = periphOut[i];
            oeNext[i]  = periphOe[i];
          end else begin
            // Snapshot value, so the entry edge does not drop the pad
            outNext[i] = holdOutNext[i];
            oeNext[i]  = holdOeNext[i];
          end
          ieNext[i] = 1'b1;
        end
        if (useGpio) begin
          outNext[i] = portOut[i];
          oeNext[i]  = portOe[i];
          ieNext[i]  = 1'b1;
        end
        if (padFunc[i] == lpsc_pkg::LPSC_FN_XTAL_OUT && powerMode != lpsc_pkg::LPSC_MODE_RUN
            && !mainOscRunning) begin
          oeNext[i] = 1'b0;
          ieNext[i] = 1'b0;
        end
        if (padFunc[i] == lpsc_pkg::LPSC_FN_WAKEUP && (powerMode == lpsc_pkg::LPSC_MODE_DEEP
            || powerMode == lpsc_pkg::LPSC_MODE_DEEP_RET)) begin
          wkNext[i] = 1'b1;
          if (standbyPinLevel || powerMode == lpsc_pkg::LPSC_MODE_DEEP_RET) begin
            oeNext[i] = 1'b0;
          end
        end
      end
      if (padFunc[i] == lpsc_pkg::LPSC_FN_ANALOG) begin
        oeNext[i] = 1'b0;
        ieNext[i] = 1'b0;
        aeNext[i] = 1'b1;
      end
      if (padFunc[i] == lpsc_pkg::LPSC_FN_CLK_IN) begin
        oeNext[i] = 1'b0;
        ieNext[i] = 1'b1;
      end
      if (!oeNext[i]) begin
        outNext[i] = 1'b0;
      end
    end
  end

  // Register every pad output
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      outReg <= {PADS{lpsc_pkg::LPSC_RST_OUT}};
      oeReg  <= {PADS{lpsc_pkg::LPSC_RST_OE}};
      ieReg  <= {PADS{lpsc_pkg::LPSC_RST_IE}};
      aeReg  <= {PADS{lpsc_pkg::LPSC_RST_AE}};
      wkReg  <= '0;
      coreIn <= '0;
    end else begin
      outReg <= outNext;
      oeReg  <= oeNext;
      ieReg  <= ieNext;
      aeReg  <= aeNext;
      wkReg  <= wkNext;
      coreIn <= ieNext & padInSync;
    end
  end

  assign padOut   = outReg;
  assign padOe    = oeReg;
  assign analogEn = aeReg;
  assign wakeupIn = wkReg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic [PADS-1:0] isAna;
  logic [PADS-1:0] isClk;

  // Pads holding analog or clock input functions
  always_comb begin
    for (int k = 0; k < PADS; k++) begin
      isAna[k] = padFunc[k] == lpsc_pkg::LPSC_FN_ANALOG;
      isClk[k] = padFunc[k] == lpsc_pkg::LPSC_FN_CLK_IN;
    end
  end

  rst_float_a: assert property (!resetInSync_n |=> padOe == '0)
    else $error("pad driven during reset input");
  hiz_low_a: assert property (##1 (padOut & ~padOe) == '0)
    else $error("floating pad has data");
  gate_low_a: assert property (##1 (coreIn & ~$past(ieNext)) == '0)
    else $error("gated input not low");
  float_stb_a: assert property (resetInSync_n && powerMode == lpsc_pkg::LPSC_MODE_STOP && standbyPinLevel
    && padFunc[0] == lpsc_pkg::LPSC_FN_GPIO |=> !padOe[0])
    else $error("standby float failed");
  hold_port_a: assert property (resetInSync_n && lowPwr && !standbyPinLevel && padFunc[0] == lpsc_pkg::LPSC_FN_GPIO
    && !(powerMode == lpsc_pkg::LPSC_MODE_DEEP && deepGpioSel[0]) |=> padOe[0] == holdOeReg[0])
    else $error("port hold lost");
  ana_pin_a: assert property (|isAna |=> (analogEn & $past(isAna)) == $past(isAna)
    && (padOe & $past(isAna)) == '0 && (coreIn & $past(isAna)) == '0)
    else $error("analog pad wrong");
  clk_in_a: assert property (|isClk |=> (padOe & $past(isClk)) == '0
    && (coreIn & $past(isClk)) == ($past(isClk) & $past(padInSync)))
    else $error("clock input pad wrong");
  capture_a: assert property (lowPwr && !lowPwrReg |=> holdOeReg == $past(liveOe))
    else $error("capture missed");

  stop_c: cover property (powerMode == lpsc_pkg::LPSC_MODE_STOP ##1 powerMode == lpsc_pkg::LPSC_MODE_RUN);
  deep_c: cover property (powerMode == lpsc_pkg::LPSC_MODE_DEEP && standbyPinLevel);
  wake_c: cover property (|wakeupIn);

endmodule : lpsc_pad_ctrl

// ### hw/lpsc_pkg.sv
// Notes on behaviour
// - Reset input low forces reset pad state, except on analog and clock input pads
// - Standby pin level picks hold or float
// - High impedance turns output drive fully off
// - Gated input presents constant low internally
// - Held pad follows still-running peripheral
// - Held port output keeps last value
// - Deep standby hands marked pins to GPIO; in LPSC_MODE_DEEP only while the standby pin level is low
// - Main clock input pin always input-enabled
// - Crystal output holds; floats when oscillator stops
// - Analog pin: driver off, input low, analog on
// - Wakeup path on; float when level bit set
package lpsc_pkg;

  // ****************************************
  // Power and reset modes
  // ****************************************
  typedef enum logic [2:0] {
    LPSC_MODE_POR,
    LPSC_MODE_INT_RST,
    LPSC_MODE_RUN,
    LPSC_MODE_STOP,
    LPSC_MODE_DEEP,
    LPSC_MODE_DEEP_RET
  } lpsc_mode_t;

  // ****************************************
  // Pad function selections
  // ****************************************
  typedef enum logic [2:0] {
    LPSC_FN_GPIO,
    LPSC_FN_PERIPH,
    LPSC_FN_ANALOG,
    LPSC_FN_CLK_IN,
    LPSC_FN_XTAL_OUT,
    LPSC_FN_WAKEUP
  } lpsc_fn_t;

  // Reset values of pad outputs
  localparam logic LPSC_RST_OUT = 1'b0;
  localparam logic LPSC_RST_OE  = 1'b0;
  localparam logic LPSC_RST_IE  = 1'b0;
  localparam logic LPSC_RST_AE  = 1'b0;

  // Default pad count
  localparam int LPSC_PADS = 8;

endpackage : lpsc_pkg

// ### hw/lpsc_sync2.sv
module lpsc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  // Refuse a width the logic cannot serve
  if (W < 1) begin : gBadWidth
    $error("W must be at least one");
  end

  logic [W-1:0] stage1Reg;
  logic [W-1:0] stage2Reg;

  // Two flop synchroniser
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1Reg <= '0;
      stage2Reg <= '0;
    end else begin
      stage1Reg <= asyncIn;
      stage2Reg <= stage1Reg;
    end
  end

  assign syncOut = stage2Reg;

endmodule : lpsc_sync2

// ### verif/low_power_pad_state_control_tb.sv
module low_power_pad_state_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Signals
  // ****
  logic sys_clk, rst_n, externalResetInput_n, standbyPinLevel, mainOscRunning;
  lpsc_pkg::lpsc_mode_t powerMode;
  lpsc_pkg::lpsc_fn_t   padFunc [8];
  logic [7:0] periphActive, periphOut, periphOe, portOut, portOe, deepGpioSel, padIn;
  logic [7:0] padOut, padOe, coreIn, analogEn, wakeupIn, boardDrv, boardLvl, capOut, liveOut;
  int error_cnt = 0;
  int total_checks = 0;
  int w;
  lpsc_pad_ctrl #(.PADS(8)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .externalResetInput_n(externalResetInput_n), .powerMode(powerMode), .standbyPinLevel(standbyPinLevel),
    .mainOscRunning(mainOscRunning), .padFunc(padFunc), .periphActive(periphActive), .periphOut(periphOut),
    .periphOe(periphOe), .portOut(portOut), .portOe(portOe), .deepGpioSel(deepGpioSel), .padIn(padIn),
    .padOut(padOut), .padOe(padOe), .coreIn(coreIn), .analogEn(analogEn), .wakeupIn(wakeupIn));
  lpsc_board_model #(.PADS(8)) board_u (.sys_clk(sys_clk), .padOut(padOut), .padOe(padOe),
    .boardDrv(boardDrv), .boardLvl(boardLvl), .padIn(padIn));
  // Clock at 20 MHz
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // ****
  // Helpers
  // ****
  function automatic logic [7:0] heldExp(input logic [7:0] cap, input logic [7:0] live, input logic [7:0] act);
    return (act & live) | (~act & cap);
  endfunction : heldExp
  task automatic check(input string what, input logic [7:0] m, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if ((got & m) !== (exp & m)) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp & m, got & m);
    end
  endtask : check
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle
  task automatic setMode(input lpsc_pkg::lpsc_mode_t m, input logic lvl);
    @(posedge sys_clk);
    powerMode       <= m;
    standbyPinLevel <= lvl;
    settle(6);
  endtask : setMode
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict
  // ****
  // Main sequence
  // ****
  initial begin
    rst_n = 1'b0; externalResetInput_n = 1'b1; powerMode = lpsc_pkg::LPSC_MODE_RUN; standbyPinLevel = 1'b0;
    mainOscRunning = 1'b1; periphActive = 8'h02; periphOut = 8'h00; periphOe = 8'hff; portOut = 8'h00;
    portOe = 8'hff; deepGpioSel = 8'h00; boardDrv = 8'h08; boardLvl = 8'h08;
    padFunc = '{lpsc_pkg::LPSC_FN_GPIO, lpsc_pkg::LPSC_FN_PERIPH, lpsc_pkg::LPSC_FN_ANALOG,
      lpsc_pkg::LPSC_FN_CLK_IN, lpsc_pkg::LPSC_FN_XTAL_OUT, lpsc_pkg::LPSC_FN_WAKEUP,
      lpsc_pkg::LPSC_FN_GPIO, lpsc_pkg::LPSC_FN_PERIPH};
    void'($urandom(32'h2cf6));
    capOut = 8'($urandom);
    repeat (12) @(posedge sys_clk);
    rst_n   <= 1'b1;
    portOut <= capOut;
    settle(6);
    check("run out", 8'h41, capOut, padOut);
    check("run oe", 8'h41, 8'hff, padOe);
    $display("test run done");
    // Stop with hold: port frozen, live peripheral followed
    @(posedge sys_clk);
    mainOscRunning <= 1'b0;
    setMode(lpsc_pkg::LPSC_MODE_STOP, 1'b0);
    liveOut = 8'($urandom);
    @(posedge sys_clk);
    portOut   <= ~capOut;
    periphOut <= liveOut;
    settle(6);
    check("hold out", 8'h43, heldExp(capOut, liveOut, 8'h02), padOut);
    check("hold oe", 8'h43, 8'hff, padOe);
    check("xtal oe", 8'h10, 8'h00, padOe);
    check("xtal in", 8'h10, 8'h00, coreIn);
    setMode(lpsc_pkg::LPSC_MODE_STOP, 1'b1);
    check("float oe", 8'h41, 8'h00, padOe);
    check("gated in", 8'h41, 8'h00, coreIn);
    $display("test stop done");
    // Deep standby hands pad 1 to the port
    capOut = 8'($urandom);
    @(posedge sys_clk);
    deepGpioSel <= 8'h02;
    portOut     <= capOut;
    setMode(lpsc_pkg::LPSC_MODE_DEEP, 1'b0);
    check("deep out", 8'h02, capOut, padOut);
    check("deep oe", 8'h02, 8'hff, padOe);
    check("wake path", 8'h20, 8'hff, wakeupIn);
    setMode(lpsc_pkg::LPSC_MODE_DEEP, 1'b1);
    check("wake oe", 8'h20, 8'h00, padOe);
    check("wake path", 8'h20, 8'hff, wakeupIn);
    $display("test deep done");
    // Analog and clock input pads in every mode and level
    for (int i = 0; i < 12; i++) begin
      setMode(lpsc_pkg::lpsc_mode_t'(3'(i % 6)), 1'(i / 6));
      check("ana oe", 8'h04, 8'h00, padOe);
      check("ana in", 8'h04, 8'h00, coreIn);
      check("ana en", 8'h04, 8'hff, analogEn);
      check("clk in", 8'h08, 8'hff, coreIn);
    end
    $display("test modes done");
    // External reset pin held low in run
    @(posedge sys_clk);
    deepGpioSel <= 8'h00;
    setMode(lpsc_pkg::LPSC_MODE_RUN, 1'b0);
    @(posedge sys_clk);
    externalResetInput_n <= 1'b0;
    for (w = 0; w < 8 && padOe[0] !== 1'b0; w++) @(negedge sys_clk);
    if (w == 8) begin
      error_cnt++;
      $display("mismatch reset wait expected float seen driving");
    end else begin
      settle(10);
      check("rst oe", 8'hc3, 8'h00, padOe);
      check("rst in", 8'h41, 8'h00, coreIn);
      check("rst ana", 8'h04, 8'hff, analogEn);
    end
    $display("test reset done");
    print_verdict();
  end
endmodule : low_power_pad_state_control_tb

// ### verif/lpsc_board_model.sv
// ****
// Board side of the pads
// ****
module lpsc_board_model #(
  parameter int PADS = 8
) (
  input  wire logic            sys_clk,
  input  wire logic [PADS-1:0] padOut,
  input  wire logic [PADS-1:0] padOe,
  input  wire logic [PADS-1:0] boardDrv,
  input  wire logic [PADS-1:0] boardLvl,
  output logic      [PADS-1:0] padIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [PADS-1:0] floatPat = '0;
  // Released pins wander each cycle so a stale level never passes
  always @(posedge sys_clk) begin
    floatPat <= ~floatPat;
  end
  // Pad drive wins, then board drivers, else floating
  assign padIn = (padOe & padOut) | (~padOe & boardDrv & boardLvl) | (~padOe & ~boardDrv & floatPat);
endmodule : lpsc_board_model
